//--- hw/psp_defines.svh
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH

// =============================================================
// Register map of the plain register port.
`define PSP_ADDR_W 4
`define PSP_OFF_S_DATA 4'h0
`define PSP_OFF_S_DIR 4'h1
`define PSP_OFF_P_DRIVE 4'h2
`define PSP_OFF_FUNC_EN 4'h3
`define PSP_OFF_P_DIR 4'h4
`define PSP_OFF_P_DATA 4'h5

// =============================================================
// Reset values.
`define PSP_RST_S_DATA 8'h00
`define PSP_RST_S_DIR 8'h00
`define PSP_RST_P_DRIVE 8'h00
`define PSP_RST_FUNC_EN 8'h00
`define PSP_RST_P_DIR 8'h00
`define PSP_RST_P_DATA 8'h00

// =============================================================
// Function enable register field positions.
`define PSP_FEN_SPI 0
`define PSP_FEN_BUSCLK 1
`define PSP_FEN_SER 2
`define PSP_FEN_PWM 3

// =============================================================
// Port S bit positions carrying alternate functions.
`define PSP_S_SS 5
`define PSP_S_SCK 4
`define PSP_S_B3 3
`define PSP_S_B2 2

`endif

//--- hw/psp_pkg.sv
package psp_pkg;

    // =============================================================
    // Owner of one port S pin.
    typedef enum logic [2:0] {
        OWN_GPIO,
        OWN_SPI,
        OWN_BUSCLK,
        OWN_SER,
        OWN_PWM
    } owner_type;

    // One pin's drive request: enable, level and reduced drive.
    typedef struct packed {
        logic oe;
        logic level;
        logic reduced;
    } pin_drive_type;

    // Alternate function requests towards port S.
    typedef struct packed {
        logic spiSsOe;
        logic spiSsOut;
        logic spiSckOe;
        logic spiSckOut;
        logic spiMosiOe;
        logic spiMosiOut;
        logic spiMisoOe;
        logic spiMisoOut;
        logic busClkOut;
        logic serTx3Oe;
        logic serTx3Out;
        logic serTx2Oe;
        logic serTx2Out;
        logic pwm3Out;
        logic pwm2Out;
    } alt_req_type;

endpackage : psp_pkg

//--- hw/psp_sync.sv
`timescale 1ns/1ps

// =============================================================
// Two-stage synchroniser for a bus of pin levels.
module psp_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Data.
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // The first stage is read only by the second, to contain metastability.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
        end
    end

    assign syncOut = stage2_reg;

endmodule : psp_sync

//--- hw/psp_s_arbiter.sv
`timescale 1ns/1ps
`include "psp_defines.svh"

// =============================================================
// Port S pin ownership by fixed priority.
module psp_s_arbiter #(
    parameter int WIDTH = 6
) (
    // Function enables.
    input wire logic spiEn,
    input wire logic busClkEn,
    input wire logic serEn,
    input wire logic pwmEn,
    // Alternate requests.
    input wire psp_pkg::alt_req_type alt,
    // General-purpose state.
    input wire logic [WIDTH-1:0] gpioDir,
    input wire logic [WIDTH-1:0] gpioData,
    // Results.
    output logic [WIDTH-1:0] pinOe,
    output logic [WIDTH-1:0] pinOut,
    output psp_pkg::owner_type owner3,
    output psp_pkg::owner_type owner2
);

    logic [WIDTH-1:0] altOwns;
    logic [WIDTH-1:0] altOe;
    logic [WIDTH-1:0] altOut;

    // Bit 3: bus clock, then MOSI, then serial, then PWM, then GPIO.
    assign owner3 = busClkEn ? psp_pkg::OWN_BUSCLK :
                    spiEn ? psp_pkg::OWN_SPI :
                    serEn ? psp_pkg::OWN_SER :
                    pwmEn ? psp_pkg::OWN_PWM : psp_pkg::OWN_GPIO;
    // Bit 2: MISO, then serial, then PWM, then GPIO.
    assign owner2 = spiEn ? psp_pkg::OWN_SPI :
                    serEn ? psp_pkg::OWN_SER :
                    pwmEn ? psp_pkg::OWN_PWM : psp_pkg::OWN_GPIO;

    // Alternate drive per bit; the bus clock and PWM always drive.
    always_comb begin
        altOwns = '0;
        altOe = '0;
        altOut = '0;
        altOwns[`PSP_S_SS] = spiEn;
        altOe[`PSP_S_SS] = alt.spiSsOe;
        altOut[`PSP_S_SS] = alt.spiSsOut;
        altOwns[`PSP_S_SCK] = spiEn;
        altOe[`PSP_S_SCK] = alt.spiSckOe;
        altOut[`PSP_S_SCK] = alt.spiSckOut;
        altOwns[`PSP_S_B3] = (owner3 != psp_pkg::OWN_GPIO);
        unique case (owner3)
            psp_pkg::OWN_BUSCLK: begin
                altOe[`PSP_S_B3] = 1'b1;
                altOut[`PSP_S_B3] = alt.busClkOut;
            end
            psp_pkg::OWN_SPI: begin
                altOe[`PSP_S_B3] = alt.spiMosiOe;
                altOut[`PSP_S_B3] = alt.spiMosiOut;
            end
            psp_pkg::OWN_SER: begin
                altOe[`PSP_S_B3] = alt.serTx3Oe;
                altOut[`PSP_S_B3] = alt.serTx3Out;
            end
            psp_pkg::OWN_PWM: begin
                altOe[`PSP_S_B3] = 1'b1;
                altOut[`PSP_S_B3] = alt.pwm3Out;
            end
            default: begin
                altOe[`PSP_S_B3] = 1'b0;
            end
        endcase
        altOwns[`PSP_S_B2] = (owner2 != psp_pkg::OWN_GPIO);
        unique case (owner2)
            psp_pkg::OWN_SPI: begin
                altOe[`PSP_S_B2] = alt.spiMisoOe;
                altOut[`PSP_S_B2] = alt.spiMisoOut;
            end
            psp_pkg::OWN_SER: begin
                altOe[`PSP_S_B2] = alt.serTx2Oe;
                altOut[`PSP_S_B2] = alt.serTx2Out;
            end
            psp_pkg::OWN_PWM: begin
                altOe[`PSP_S_B2] = 1'b1;
                altOut[`PSP_S_B2] = alt.pwm2Out;
            end
            default: begin
                altOe[`PSP_S_B2] = 1'b0;
            end
        endcase
    end

    // GPIO drives the data bit only where no alternate function owns the pin.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_pin
            assign pinOe[i] = altOwns[i] ? altOe[i] : gpioDir[i];
            assign pinOut[i] = altOwns[i] ? altOut[i] : gpioData[i];
        end
    endgenerate

endmodule : psp_s_arbiter

//--- hw/psp_port_top.sv
// =============================================================
// Summary of operation
// - GPIO output drives stored data bit
// - Read returns data if output, else pin
// - Enabled SPI owns port S bits 5, 4
// - Bit 3: clock, MOSI, serial, PWM, GPIO
// - Bit 2: MISO, serial, PWM, GPIO
// - Alternate functions mapped to fixed S bits
// - Drive bit set selects reduced drive
// - Drive bit ignored on inputs, any function
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "psp_defines.svh"

module psp_port_top #(
    parameter int S_WIDTH = 6,
    parameter int P_WIDTH = 6
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register port.
    input wire logic [`PSP_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // Alternate function requests.
    input wire psp_pkg::alt_req_type altReq,
    // Port S pins.
    input wire logic [S_WIDTH-1:0] portSIn,
    output logic [S_WIDTH-1:0] portSOut,
    output logic [S_WIDTH-1:0] portSOe,
    // Alternate function inputs seen from port S.
    output logic [S_WIDTH-1:0] portSSync,
    // Port P pins.
    input wire logic [P_WIDTH-1:0] portPIn,
    input wire logic [P_WIDTH-1:0] portPAltOe,
    input wire logic [P_WIDTH-1:0] portPAltOut,
    input wire logic [P_WIDTH-1:0] portPAltOwn,
    output logic [P_WIDTH-1:0] portPOut,
    output logic [P_WIDTH-1:0] portPOe,
    output logic [P_WIDTH-1:0] portPReduced
);

    // =============================================================
    // Registers.
    logic [7:0] sData_reg;
    logic [7:0] sData_next;
    logic [7:0] sDir_reg;
    logic [7:0] sDir_next;
    logic [7:0] pDrive_reg;
    logic [7:0] pDrive_next;
    logic [7:0] funcEn_reg;
    logic [7:0] funcEn_next;
    logic [7:0] pDir_reg;
    logic [7:0] pDir_next;
    logic [7:0] pData_reg;
    logic [7:0] pData_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [S_WIDTH-1:0] sOut_reg;
    logic [S_WIDTH-1:0] sOe_reg;
    logic [S_WIDTH-1:0] sSync_reg;
    logic [P_WIDTH-1:0] pOut_reg;
    logic [P_WIDTH-1:0] pOe_reg;
    logic [P_WIDTH-1:0] pRed_reg;

    // =============================================================
    // Synchronised pin levels.
    logic [S_WIDTH-1:0] sPinSync;
    logic [P_WIDTH-1:0] pPinSync;

    psp_sync #(.WIDTH(S_WIDTH)) u_sync_s (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .asyncIn(portSIn),
        .syncOut(sPinSync)
    );

    psp_sync #(.WIDTH(P_WIDTH)) u_sync_p (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .asyncIn(portPIn),
        .syncOut(pPinSync)
    );

    // =============================================================
    // Port S ownership.
    logic [S_WIDTH-1:0] sOeNext;
    logic [S_WIDTH-1:0] sOutNext;

    psp_s_arbiter #(.WIDTH(S_WIDTH)) u_arb (
        .spiEn(funcEn_reg[`PSP_FEN_SPI]),
        .busClkEn(funcEn_reg[`PSP_FEN_BUSCLK]),
        .serEn(funcEn_reg[`PSP_FEN_SER]),
        .pwmEn(funcEn_reg[`PSP_FEN_PWM]),
        .alt(altReq),
        .gpioDir(sDir_reg[S_WIDTH-1:0]),
        .gpioData(sData_reg[S_WIDTH-1:0]),
        .pinOe(sOeNext),
        .pinOut(sOutNext),
        .owner3(),
        .owner2()
    );

    // =============================================================
    // Port P drive: the reduced flag is meaningful only while driving.
    logic [P_WIDTH-1:0] pOeNext;
    logic [P_WIDTH-1:0] pOutNext;
    logic [P_WIDTH-1:0] pRedNext;

    genvar j;
    generate
        for (j = 0; j < P_WIDTH; j++) begin : g_pp
            assign pOeNext[j] = portPAltOwn[j] ? portPAltOe[j] : pDir_reg[j];
            assign pOutNext[j] = portPAltOwn[j] ? portPAltOut[j] : pData_reg[j];
            assign pRedNext[j] = pOeNext[j] & pDrive_reg[j];
        end
    endgenerate

    // =============================================================
    // Register decode.
    logic hitSData;
    logic hitSDir;
    logic hitPDrive;
    logic hitFunc;
    logic hitPDir;
    logic hitPData;
    logic [7:0] sReadVal;
    logic [7:0] pReadVal;

    function automatic logic hit(input logic [`PSP_ADDR_W-1:0] a,
                                 input logic [`PSP_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    assign hitSData = hit(regAddr, `PSP_OFF_S_DATA);
    assign hitSDir = hit(regAddr, `PSP_OFF_S_DIR);
    assign hitPDrive = hit(regAddr, `PSP_OFF_P_DRIVE);
    assign hitFunc = hit(regAddr, `PSP_OFF_FUNC_EN);
    assign hitPDir = hit(regAddr, `PSP_OFF_P_DIR);
    assign hitPData = hit(regAddr, `PSP_OFF_P_DATA);

    // Output bits read back the register, input bits the synchronised pin.
    assign sReadVal = {{(8 - S_WIDTH){1'b0}},
                       (sDir_reg[S_WIDTH-1:0] & sData_reg[S_WIDTH-1:0]) |
                       (~sDir_reg[S_WIDTH-1:0] & sPinSync)};
    assign pReadVal = {{(8 - P_WIDTH){1'b0}},
                       (pDir_reg[P_WIDTH-1:0] & pData_reg[P_WIDTH-1:0]) |
                       (~pDir_reg[P_WIDTH-1:0] & pPinSync)};

    // Writes store all eight bits; unmapped addresses read zero.
    assign sData_next = (regWr && hitSData) ? regWdata : sData_reg;
    assign sDir_next = (regWr && hitSDir) ? regWdata : sDir_reg;
    assign pDrive_next = (regWr && hitPDrive) ? regWdata : pDrive_reg;
    assign funcEn_next = (regWr && hitFunc) ? regWdata : funcEn_reg;
    assign pDir_next = (regWr && hitPDir) ? regWdata : pDir_reg;
    assign pData_next = (regWr && hitPData) ? regWdata : pData_reg;
    assign rdata_next = !regRd ? 8'h00 :
                        hitSData ? sReadVal :
                        hitSDir ? sDir_reg :
                        hitPDrive ? pDrive_reg :
                        hitFunc ? funcEn_reg :
                        hitPDir ? pDir_reg :
                        hitPData ? pReadVal : 8'h00;

    // =============================================================
    // Register state.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sData_reg <= `PSP_RST_S_DATA;
            sDir_reg <= `PSP_RST_S_DIR;
            pDrive_reg <= `PSP_RST_P_DRIVE;
            funcEn_reg <= `PSP_RST_FUNC_EN;
            pDir_reg <= `PSP_RST_P_DIR;
            pData_reg <= `PSP_RST_P_DATA;
            rdata_reg <= 8'h00;
        end else begin
            sData_reg <= sData_next;
            sDir_reg <= sDir_next;
            pDrive_reg <= pDrive_next;
            funcEn_reg <= funcEn_next;
            pDir_reg <= pDir_next;
            pData_reg <= pData_next;
            rdata_reg <= rdata_next;
        end
    end

    // =============================================================
    // Pin outputs are registered so every output leaves a flip-flop;
    // this costs one cycle of latency on alternate function signals.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sOut_reg <= '0;
            sOe_reg <= '0;
            sSync_reg <= '0;
            pOut_reg <= '0;
            pOe_reg <= '0;
            pRed_reg <= '0;
        end else begin
            sOut_reg <= sOutNext;
            sOe_reg <= sOeNext;
            sSync_reg <= sPinSync;
            pOut_reg <= pOutNext;
            pOe_reg <= pOeNext;
            pRed_reg <= pRedNext;
        end
    end

    assign regRdata = rdata_reg;
    assign portSOut = sOut_reg;
    assign portSOe = sOe_reg;
    assign portSSync = sSync_reg;
    assign portPOut = pOut_reg;
    assign portPOe = pOe_reg;
    assign portPReduced = pRed_reg;

endmodule : psp_port_top

//--- testbench/psp_port_chk.sv
`timescale 1ns/1ps
`include "psp_defines.svh"

// =====
// Checker for pin ownership, drive and reads.
module psp_port_chk #(
    parameter int S_WIDTH = 6,
    parameter int P_WIDTH = 6
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register port.
    input wire logic [`PSP_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    // Port S.
    input wire psp_pkg::alt_req_type altReq,
    input wire logic [S_WIDTH-1:0] portSIn,
    input wire logic [S_WIDTH-1:0] portSOut,
    input wire logic [S_WIDTH-1:0] portSOe,
    input wire logic [S_WIDTH-1:0] portSSync,
    // Port P.
    input wire logic [P_WIDTH-1:0] portPIn,
    input wire logic [P_WIDTH-1:0] portPAltOe,
    input wire logic [P_WIDTH-1:0] portPAltOut,
    input wire logic [P_WIDTH-1:0] portPAltOwn,
    input wire logic [P_WIDTH-1:0] portPOut,
    input wire logic [P_WIDTH-1:0] portPOe,
    input wire logic [P_WIDTH-1:0] portPReduced
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // Shadows follow the writes; pin checks wait until the pins sat still.
    logic [7:0] sDat_reg, sDir_reg, pDrv_reg, fen_reg, pDir_reg, pDat_reg;
    logic [S_WIDTH-1:0] pin_reg;
    logic [2:0] stab_reg;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            {sDat_reg, sDir_reg, pDrv_reg, fen_reg, pDir_reg, pDat_reg} <= '0;
            pin_reg <= '0;
            stab_reg <= 3'h0;
        end else begin
            pin_reg <= portSIn;
            if (portSIn != pin_reg) stab_reg <= 3'h0;
            else if (stab_reg != 3'h7) stab_reg <= stab_reg + 3'h1;
            if (regWr && regAddr == `PSP_OFF_S_DATA) sDat_reg <= regWdata;
            if (regWr && regAddr == `PSP_OFF_S_DIR) sDir_reg <= regWdata;
            if (regWr && regAddr == `PSP_OFF_P_DRIVE) pDrv_reg <= regWdata;
            if (regWr && regAddr == `PSP_OFF_FUNC_EN) fen_reg <= regWdata;
            if (regWr && regAddr == `PSP_OFF_P_DIR) pDir_reg <= regWdata;
            if (regWr && regAddr == `PSP_OFF_P_DATA) pDat_reg <= regWdata;
        end
    end

    // Expected owners of bits 3 and 2, port P drive and read data.
    wire [1:0] e3 = fen_reg[1] ? {1'b1, altReq.busClkOut}
        : fen_reg[0] ? {altReq.spiMosiOe, altReq.spiMosiOut}
        : fen_reg[2] ? {altReq.serTx3Oe, altReq.serTx3Out}
        : fen_reg[3] ? {1'b1, altReq.pwm3Out} : {sDir_reg[3], sDat_reg[3]};
    wire [1:0] e2 = fen_reg[0] ? {altReq.spiMisoOe, altReq.spiMisoOut}
        : fen_reg[2] ? {altReq.serTx2Oe, altReq.serTx2Out}
        : fen_reg[3] ? {1'b1, altReq.pwm2Out} : {sDir_reg[2], sDat_reg[2]};
    wire [P_WIDTH-1:0] own = portPAltOwn;
    wire [P_WIDTH-1:0] pOeE = (own & portPAltOe) | (~own & pDir_reg[P_WIDTH-1:0]);
    wire [P_WIDTH-1:0] pOutE = (own & portPAltOut) | (~own & pDat_reg[P_WIDTH-1:0]);
    wire [5:0] rdE = (sDir_reg[5:0] & sDat_reg[5:0]) | (~sDir_reg[5:0] & pin_reg[5:0]);

    sequence s_rd_data;
        regRd && regAddr == `PSP_OFF_S_DATA && stab_reg >= 3'h5;
    endsequence

    a_rd_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_read_mix: assert property (s_rd_data |=> regRdata == {2'h0, $past(rdE)})
        else $error("port S read mixes data and pins wrongly");
    a_gpio_drive: assert property ($past(fen_reg[3:0]) == 4'h0 |->
        portSOe == $past(sDir_reg[5:0]) && (portSOut & portSOe) == $past(rdE & sDir_reg[5:0]))
        else $error("general output does not drive stored data");
    a_spi_high: assert property ($past(fen_reg[0]) |->
        {portSOe[5:4], portSOut[5:4] & portSOe[5:4]} == $past({altReq.spiSsOe,
        altReq.spiSckOe, altReq.spiSsOut & altReq.spiSsOe, altReq.spiSckOut & altReq.spiSckOe}))
        else $error("enabled select or clock not owning bits 5 and 4");
    a_bit3_prio: assert property ({portSOe[3], portSOut[3] & portSOe[3]} == $past({e3[1], &e3}))
        else $error("bit 3 owner wrong");
    a_bit2_prio: assert property ({portSOe[2], portSOut[2] & portSOe[2]} == $past({e2[1], &e2}))
        else $error("bit 2 owner wrong");
    a_reduced_oe: assert property (portPReduced == (portPOe & $past(pDrv_reg[P_WIDTH-1:0])))
        else $error("reduced drive not following select and enable");
    a_p_owner: assert property ({portPOe, portPOut & portPOe} == $past({pOeE, pOutE & pOeE}))
        else $error("port P drive wrong");
    a_sync_settle: assert property (stab_reg >= 3'h5 |-> portSSync == pin_reg)
        else $error("synchronised pins not settled");
endmodule : psp_port_chk

//--- testbench/psp_pin_model.sv
`timescale 1ns/1ps

// =====
// Outside circuitry on one port.
module psp_pin_model #(
    parameter int W = 6
) (
    // Device side.
    input wire logic [W-1:0] pinOut,
    input wire logic [W-1:0] pinOe,
    // Outside source.
    input wire logic [W-1:0] extLevel,
    output logic [W-1:0] pinLevel
);
    // A driven pin shows the device, an undriven one the outside source.
    assign pinLevel = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : psp_pin_model

//--- testbench/test_psp_port_top.sv
`timescale 1ns/1ps
`include "psp_defines.svh"

// =====
// Bench for the port block.
module test_psp_port_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [`PSP_ADDR_W-1:0] regAddr = '0;
    logic [7:0] regWdata = '0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata;
    psp_pkg::alt_req_type altReq = '0;
    logic [5:0] portSIn, portSOut, portSOe, portSSync, sExt = '0;
    logic [5:0] portPIn, portPOut, portPOe, portPReduced, pExt = '0;
    logic [5:0] portPAltOe = '0, portPAltOut = '0, portPAltOwn = '0;
    int miscompares = 0;
    int cmp_count = 0;

    // Clock of 4 ns.
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    psp_port_top #(.S_WIDTH(6), .P_WIDTH(6)) dut (
        .ref_clk, .rst_b, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .altReq,
        .portSIn, .portSOut, .portSOe, .portSSync, .portPIn, .portPAltOe, .portPAltOut,
        .portPAltOwn, .portPOut, .portPOe, .portPReduced
    );
    psp_pin_model #(.W(6)) sSide (.pinOut(portSOut), .pinOe(portSOe), .extLevel(sExt),
        .pinLevel(portSIn));
    psp_pin_model #(.W(6)) pSide (.pinOut(portPOut), .pinOe(portPOe), .extLevel(pExt),
        .pinLevel(portPIn));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] got);
        cmp_count++;
        if (got !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, got);
        end
    endtask : chk

    // Writes leave the strobe up so a read may follow at once.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regRd <= 1'b0;
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
    endtask : wr

    task automatic idle(input int n);
        @(posedge ref_clk);
        regWr <= 1'b0;
        regRd <= 1'b0;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        chk($sformatf("read of %h", a), e, regRdata);
    endtask : rd

    // Owners of bits 5 to 2 with GPIO direction 3c and data 28.
    function automatic logic [7:0] expS(input logic [3:0] f, input psp_pkg::alt_req_type q);
        logic [3:0] oe, o;
        {oe[3:2], o[3:2]} = f[0] ? {q.spiSsOe, q.spiSckOe, q.spiSsOut, q.spiSckOut} : 4'he;
        {oe[1], o[1]} = f[1] ? {1'b1, q.busClkOut} : f[0] ? {q.spiMosiOe, q.spiMosiOut}
            : f[2] ? {q.serTx3Oe, q.serTx3Out} : f[3] ? {1'b1, q.pwm3Out} : 2'h3;
        {oe[0], o[0]} = f[0] ? {q.spiMisoOe, q.spiMisoOut} : f[2] ? {q.serTx2Oe, q.serTx2Out}
            : f[3] ? {1'b1, q.pwm2Out} : 2'h2;
        return {oe, o & oe};
    endfunction : expS

    task automatic t_reset();
        @(posedge ref_clk);
        rst_b <= 1'b0;
        regWr <= 1'b0;
        sExt <= 6'h00;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        #1;
        chk("pin enables", 8'h00, {2'h0, portSOe | portPOe});
        for (int a = 0; a < 8; a++) rd(a[3:0], 8'h00);
        $display("reset test done");
    endtask : t_reset

    task automatic t_regs();
        // Port P data reads its three output bits; the undriven input pins read low.
        for (int a = 1; a < 6; a++) begin
            wr(a[3:0], 8'hc3 ^ a[7:0]);
            rd(a[3:0], (a == 5) ? 8'h06 : 8'hc3 ^ a[7:0]);
        end
        wr(4'h9, 8'hff);
        rd(4'h9, 8'h00);
        for (int a = 1; a < 6; a++) wr(a[3:0], 8'h00);
        idle(2);
        $display("register test done");
    endtask : t_regs

    task automatic t_gpio();
        @(posedge ref_clk);
        sExt <= 6'h2a;
        wr(`PSP_OFF_S_DIR, 8'h0f);
        wr(`PSP_OFF_S_DATA, 8'hf5);
        idle(6);
        chk("port S enable", 8'h0f, {2'h0, portSOe});
        chk("port S level", 8'h05, {2'h0, portSOut & portSOe});
        rd(`PSP_OFF_S_DATA, 8'h25);
        $display("general pin test done");
    endtask : t_gpio

    // Two opposite request patterns tell every pair of owners apart except the bus clock and PWM on bit 3.
    task automatic t_prio();
        psp_pkg::alt_req_type q;
        wr(`PSP_OFF_S_DIR, 8'h3c);
        wr(`PSP_OFF_S_DATA, 8'h28);
        for (int k = 0; k < 32; k++) begin
            q = k[4] ? 15'h4f90 : ~15'h4f90;
            wr(`PSP_OFF_FUNC_EN, {4'h0, k[3:0]});
            altReq <= q;
            idle(3);
            chk("port S owners", expS(k[3:0], q), {portSOe[5:2], portSOut[5:2] & portSOe[5:2]});
        end
        $display("priority test done");
    endtask : t_prio

    task automatic t_drive();
        @(posedge ref_clk);
        portPAltOwn <= 6'h30;
        portPAltOe <= 6'h10;
        portPAltOut <= 6'h3f;
        wr(`PSP_OFF_P_DIR, 8'h0f);
        wr(`PSP_OFF_P_DATA, 8'h05);
        wr(`PSP_OFF_P_DRIVE, 8'h36);
        idle(3);
        chk("port P enable", 8'h1f, {2'h0, portPOe});
        chk("port P level", 8'h15, {2'h0, portPOut & portPOe});
        chk("port P reduced", 8'h16, {2'h0, portPReduced});
        @(posedge ref_clk);
        portPAltOwn <= 6'h00;
        idle(3);
        chk("port P reduced", 8'h06, {2'h0, portPReduced});
        $display("drive test done");
    endtask : t_drive

    // A pin change must not reach reads within the two synchroniser stages.
    task automatic t_sync();
        wr(`PSP_OFF_S_DIR, 8'h00);
        wr(`PSP_OFF_FUNC_EN, 8'h00);
        @(posedge ref_clk);
        regWr <= 1'b0;
        sExt <= 6'h15;
        idle(8);
        @(posedge ref_clk);
        sExt <= 6'h2a;
        rd(`PSP_OFF_S_DATA, 8'h15);
        chk("pin sync", 8'h15, {2'h0, portSSync});
        idle(6);
        rd(`PSP_OFF_S_DATA, 8'h2a);
        chk("pin sync", 8'h2a, {2'h0, portSSync});
        $display("sync test done");
    endtask : t_sync

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // Main sequence, ending with a reset in mid-run.
    initial begin
        t_reset();
        t_regs();
        t_gpio();
        t_prio();
        t_drive();
        t_sync();
        t_reset();
        end_of_test();
    end

    // The tests need some three hundred cycles; this limit is far above.
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        end_of_test();
    end
endmodule : test_psp_port_top

bind psp_port_top psp_port_chk #(.S_WIDTH(S_WIDTH), .P_WIDTH(P_WIDTH)) u_chk (
    .ref_clk, .rst_b, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .altReq,
    .portSIn, .portSOut, .portSOe, .portSSync, .portPIn, .portPAltOe, .portPAltOut,
    .portPAltOwn, .portPOut, .portPOe, .portPReduced
);
